// [dma_crc_unit.sv]
// checksum unit in the datapath of one selected dma channel
`timescale 1ns/10ps
module dma_crc_unit #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 4,
  parameter int NUM_CH = 8,
  parameter int CH_W = 3
) (
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // source stream from the channel engine
  input wire logic src_valid,
  input wire logic [CH_W-1:0] src_chan,
  input wire logic [DATA_W-1:0] src_data,
  // block completion of a channel
  input wire logic block_done,
  input wire logic [CH_W-1:0] block_done_chan,
  // destination start address of every channel
  input wire logic [NUM_CH*DATA_W-1:0] dest_start_address,
  // destination stream
  output logic dst_valid,
  output logic [CH_W-1:0] dst_chan,
  output logic [DATA_W-1:0] dst_data,
  // appended checksum write
  output logic crc_wr_valid,
  output logic [DATA_W-1:0] crc_wr_addr,
  output logic [DATA_W-1:0] crc_wr_data
);

  // ---- control fields ----
  logic [DATA_W-1:0] ctrl_r; // control register
  logic [DATA_W-1:0] ctrl_nxt;
  logic [DATA_W-1:0] poly_r; // feedback polynomial
  logic [DATA_W-1:0] poly_nxt;
  logic [DATA_W-1:0] acc_r; // running checksum
  logic [DATA_W-1:0] acc_nxt;
  logic [DATA_W-1:0] rdata_r; // read answer
  logic [DATA_W-1:0] rdata_nxt;
  logic [1:0] order_sel; // byte order field
  logic write_order; // destination gets reordered data
  logic reflect; // bit order field
  logic [4:0] poly_len; // length minus one
  logic enable; // checksum enable
  logic append; // append mode
  logic ip_mode; // algorithm type
  logic [CH_W-1:0] chan_sel; // attached channel
  logic accept; // word of attached channel taken
  logic done_sel; // block end of attached channel
  logic [DATA_W-1:0] reordered; // source word after reordering
  logic [DATA_W-1:0] step_out; // checksum after this word
  logic [DATA_W-1:0] acc_view; // checksum as software sees it
  logic [DATA_W-1:0] final_val; // checksum including current word
  logic [DATA_W-1:0] wr_ctrl; // written control value, masked
  logic ctrl_write; // control register written this cycle

  // field views of the control register
  assign order_sel = ctrl_r[dma_crc_pkg::BYTE_ORDER_HI:dma_crc_pkg::BYTE_ORDER_LO];
  assign write_order = ctrl_r[dma_crc_pkg::WRITE_ORDER_BIT];
  assign reflect = ctrl_r[dma_crc_pkg::BIT_REFLECT_BIT];
  assign poly_len = ctrl_r[dma_crc_pkg::POLY_LEN_HI:dma_crc_pkg::POLY_LEN_LO];
  assign enable = ctrl_r[dma_crc_pkg::ENABLE_BIT];
  assign append = ctrl_r[dma_crc_pkg::APPEND_BIT];
  assign ip_mode = ctrl_r[dma_crc_pkg::ALG_TYPE_BIT];
  assign chan_sel = ctrl_r[dma_crc_pkg::CHAN_HI:dma_crc_pkg::CHAN_LO];

  // word and block events of the attached channel only
  assign accept = enable && src_valid && (src_chan == chan_sel);
  assign done_sel = enable && block_done && (block_done_chan == chan_sel);

  // byte lanes rearranged before the checksum
  byte_reorder u_reorder (
    .order_sel(order_sel),
    .din(src_data),
    .dout(reordered)
  );

  // one checksum step on the reordered word
  crc_engine #(
    .DATA_W(DATA_W)
  ) u_engine (
    .ip_mode(ip_mode),
    .reflect(reflect),
    .poly_length(poly_len),
    .poly(poly_r),
    .data_in(reordered),
    .acc_in(acc_r),
    .acc_out(step_out)
  );

  // ip mode shows the complemented sum, lfsr mode the register
  always_comb begin
    acc_view = ip_mode ? {16'h0000, ~acc_r[15:0]} : acc_r;
    final_val = ip_mode ? {16'h0000, ~step_out[15:0]} : step_out;
    if (!accept) begin
      final_val = acc_view;
    end
  end

  // ---- register file ----
  assign ctrl_write = reg_wr && (reg_addr == dma_crc_pkg::OFS_CONTROL);

  // next values of control, polynomial and read data
  always_comb begin
    ctrl_nxt = ctrl_r;
    poly_nxt = poly_r;
    rdata_nxt = dma_crc_pkg::READ_ZERO;
    // unimplemented bits never stored
    wr_ctrl = reg_wdata & dma_crc_pkg::CTRL_MASK;
    if (ctrl_write) begin
      // append cannot be set together with write order
      if (wr_ctrl[dma_crc_pkg::WRITE_ORDER_BIT]) begin
        wr_ctrl[dma_crc_pkg::APPEND_BIT] = 1'b0;
      end
      ctrl_nxt = wr_ctrl;
    end
    if (reg_wr && (reg_addr == dma_crc_pkg::OFS_POLY)) begin
      poly_nxt = reg_wdata;
    end
    // read decode, unmapped offsets answer zero
    if (reg_rd) begin
      case (reg_addr)
        dma_crc_pkg::OFS_CONTROL: rdata_nxt = ctrl_r & dma_crc_pkg::CTRL_MASK;
        dma_crc_pkg::OFS_RESULT: rdata_nxt = acc_view;
        dma_crc_pkg::OFS_POLY: rdata_nxt = poly_r;
        default: rdata_nxt = dma_crc_pkg::READ_ZERO;
      endcase
    end
  end

  // register the control state and read data
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= dma_crc_pkg::CTRL_RESET;
      poly_r <= dma_crc_pkg::POLY_RESET;
      rdata_r <= dma_crc_pkg::READ_ZERO;
    end else begin
      ctrl_r <= ctrl_nxt;
      poly_r <= poly_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  // ---- accumulator ----
  // cleared when the unit is switched on, stepped once per accepted word
  always_comb begin
    acc_nxt = acc_r;
    if (ctrl_write && !enable && wr_ctrl[dma_crc_pkg::ENABLE_BIT]) begin
      acc_nxt = dma_crc_pkg::ACC_RESET;
    end else if (accept) begin
      acc_nxt = step_out;
    end
  end

  // register the accumulator
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      acc_r <= dma_crc_pkg::ACC_RESET;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // ---- destination stream ----
  logic dst_valid_r; // destination word present
  logic dst_valid_nxt;
  logic [CH_W-1:0] dst_chan_r; // channel of that word
  logic [CH_W-1:0] dst_chan_nxt;
  logic [DATA_W-1:0] dst_data_r; // word written out
  logic [DATA_W-1:0] dst_data_nxt;

  // pass, reorder or swallow each source word
  always_comb begin
    dst_valid_nxt = src_valid;
    dst_chan_nxt = src_chan;
    dst_data_nxt = src_data;
    if (accept && append) begin
      dst_valid_nxt = 1'b0;
    end else if (accept && write_order) begin
      dst_data_nxt = reordered;
    end
  end

  // register the destination stream
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dst_valid_r <= 1'b0;
      dst_chan_r <= '0;
      dst_data_r <= '0;
    end else begin
      dst_valid_r <= dst_valid_nxt;
      dst_chan_r <= dst_chan_nxt;
      dst_data_r <= dst_data_nxt;
    end
  end
  assign dst_valid = dst_valid_r;
  assign dst_chan = dst_chan_r;
  assign dst_data = dst_data_r;

  // ---- appended checksum write ----
  logic crc_wr_valid_r; // checksum write request
  logic crc_wr_valid_nxt;
  logic [DATA_W-1:0] crc_wr_addr_r; // destination start address
  logic [DATA_W-1:0] crc_wr_addr_nxt;
  logic [DATA_W-1:0] crc_wr_data_r; // final checksum
  logic [DATA_W-1:0] crc_wr_data_nxt;

  // at block end of the attached channel, write the checksum out
  always_comb begin
    crc_wr_valid_nxt = 1'b0;
    crc_wr_addr_nxt = crc_wr_addr_r;
    crc_wr_data_nxt = crc_wr_data_r;
    if (done_sel && append) begin
      crc_wr_valid_nxt = 1'b1;
      crc_wr_addr_nxt = dest_start_address[int'(chan_sel)*DATA_W +: DATA_W];
      crc_wr_data_nxt = final_val;
    end
  end

  // register the checksum write
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      crc_wr_valid_r <= 1'b0;
      crc_wr_addr_r <= '0;
      crc_wr_data_r <= '0;
    end else begin
      crc_wr_valid_r <= crc_wr_valid_nxt;
      crc_wr_addr_r <= crc_wr_addr_nxt;
      crc_wr_data_r <= crc_wr_data_nxt;
    end
  end
  assign crc_wr_valid = crc_wr_valid_r;
  assign crc_wr_addr = crc_wr_addr_r;
  assign crc_wr_data = crc_wr_data_r;

  // ---- checks ----
  // control readback never shows unimplemented bits
  AST_RESERVED_ZERO: assert property (@(posedge ref_clk) disable iff (reset)
    (reg_rd && reg_addr == dma_crc_pkg::OFS_CONTROL) |=>
      ((reg_rdata & ~dma_crc_pkg::CTRL_MASK) == dma_crc_pkg::READ_ZERO))
    else $error("reserved control bits read nonzero");

  // append and write order never stand together
  AST_APPEND_BLOCKED: assert property (@(posedge ref_clk) disable iff (reset)
    !(ctrl_r[dma_crc_pkg::APPEND_BIT] && ctrl_r[dma_crc_pkg::WRITE_ORDER_BIT]))
    else $error("append set while write order set");

  // write with write order set leaves append clear
  AST_APPEND_WRITE_MASK: assert property (@(posedge ref_clk) disable iff (reset)
    (reg_wr && reg_addr == dma_crc_pkg::OFS_CONTROL && reg_wdata[dma_crc_pkg::WRITE_ORDER_BIT])
      |=> !append)
    else $error("append accepted with write order");

  // in append mode attached words do not reach the destination
  AST_APPEND_NO_DST: assert property (@(posedge ref_clk) disable iff (reset)
    (accept && append) |=> !dst_valid)
    else $error("appended source word reached destination");

  // disabled unit passes words unaltered
  AST_PASS_UNALTERED: assert property (@(posedge ref_clk) disable iff (reset)
    (src_valid && !enable) |=> (dst_valid && dst_data == $past(src_data)))
    else $error("disabled unit altered a word");

  // write order carries the reordered word, otherwise the raw word
  AST_WRITE_ORDER: assert property (@(posedge ref_clk) disable iff (reset)
    (accept && !append) |=>
      (dst_valid && dst_data == ($past(write_order) ? $past(reordered) : $past(src_data))))
    else $error("destination data order wrong");

  // word reversal puts the top byte at the bottom
  AST_WORD_REVERSE: assert property (@(posedge ref_clk) disable iff (reset)
    (order_sel == dma_crc_pkg::ORDER_WORD_REV) |-> (reordered[7:0] == src_data[31:24] &&
      reordered[31:24] == src_data[7:0]))
    else $error("byte reversal wrong");

  // accumulator holds while no word is taken and control is untouched
  AST_ACC_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
    (!accept && !ctrl_write) |=> $stable(acc_r))
    else $error("checksum moved without a word");

  // block end in append mode writes once to the start address
  AST_APPEND_RESULT: assert property (@(posedge ref_clk) disable iff (reset)
    (done_sel && append) |=> (crc_wr_valid &&
      crc_wr_addr == $past(dest_start_address[int'(chan_sel)*DATA_W +: DATA_W]))
      ##1 !crc_wr_valid)
    else $error("append write missing or misaddressed");

  // no checksum write while disabled
  AST_IDLE_DISABLED: assert property (@(posedge ref_clk) disable iff (reset)
    (!enable) |=> !crc_wr_valid)
    else $error("checksum written while disabled");

  // first edge after reset release sees control, checksum and both valid outputs at reset value
  AST_RESET_STATE: assert property (@(posedge ref_clk)
    $fell(reset) |-> (ctrl_r == dma_crc_pkg::CTRL_RESET && acc_r == dma_crc_pkg::ACC_RESET &&
      !dst_valid && !crc_wr_valid))
    else $error("state not at reset value after release");

  // switching the unit on starts the checksum from its reset value
  AST_ENABLE_CLEAR: assert property (@(posedge ref_clk) disable iff (reset)
    (ctrl_write && !enable && reg_wdata[dma_crc_pkg::ENABLE_BIT]) |=>
      (acc_r == dma_crc_pkg::ACC_RESET))
    else $error("checksum not cleared when enabled");

  // words of any other channel pass unaltered while the unit is on
  AST_OTHER_CHANNEL: assert property (@(posedge ref_clk) disable iff (reset)
    (src_valid && enable && src_chan != chan_sel) |=>
      (dst_valid && dst_data == $past(src_data)))
    else $error("word of another channel altered");

  // without append every word reaches the destination on its own channel
  AST_DST_CHANNEL: assert property (@(posedge ref_clk) disable iff (reset)
    (src_valid && !append) |=> (dst_valid && dst_chan == $past(src_chan)))
    else $error("word lost or channel changed");

  // no checksum write unless append mode is on
  AST_NO_APPEND_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
    (!append) |=> !crc_wr_valid)
    else $error("checksum written without append mode");

  // half-word swap keeps byte order inside each half
  AST_HALF_SWAP: assert property (@(posedge ref_clk) disable iff (reset)
    (order_sel == dma_crc_pkg::ORDER_HALF_SWAP) |->
      (reordered[31:16] == src_data[15:0] && reordered[15:0] == src_data[31:16]))
    else $error("half-word swap wrong");

  // half-word byte reversal keeps the halves in place
  AST_HALF_REVERSE: assert property (@(posedge ref_clk) disable iff (reset)
    (order_sel == dma_crc_pkg::ORDER_HALF_REV) |->
      (reordered[15:8] == src_data[7:0] && reordered[31:24] == src_data[23:16]))
    else $error("half-word byte reversal wrong");

  // ip mode reports a 16-bit sum with the upper half clear
  AST_IP_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (reset)
    (reg_rd && reg_addr == dma_crc_pkg::OFS_RESULT && ip_mode) |=>
      (reg_rdata[DATA_W-1:dma_crc_pkg::IP_W] == '0))
    else $error("ip result upper half not clear");

endmodule

// [dma_crc_pkg.sv]
// shared constants and types of the dma checksum unit
package dma_crc_pkg;
  // datapath and bus widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int IP_W = 16;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_POLY = 4'h8;
  // control field positions
  localparam int BYTE_ORDER_HI = 29;
  localparam int BYTE_ORDER_LO = 28;
  localparam int WRITE_ORDER_BIT = 27;
  localparam int BIT_REFLECT_BIT = 24;
  localparam int POLY_LEN_HI = 12;
  localparam int POLY_LEN_LO = 8;
  localparam int ENABLE_BIT = 7;
  localparam int APPEND_BIT = 6;
  localparam int ALG_TYPE_BIT = 5;
  localparam int CHAN_HI = 2;
  localparam int CHAN_LO = 0;
  // implemented control bits and reset values
  localparam logic [DATA_W-1:0] CTRL_MASK = 32'h3900_1FE7;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] POLY_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;
  // byte order codes
  typedef enum logic [1:0] {
    ORDER_KEEP = 2'h0,
    ORDER_WORD_REV = 2'h1,
    ORDER_HALF_SWAP = 2'h2,
    ORDER_HALF_REV = 2'h3
  } byte_order_t;
endpackage

// [byte_reorder.sv]
// combinational byte reordering of one source word
`timescale 1ns/10ps
module byte_reorder (
  input wire logic [1:0] order_sel,
  input wire logic [31:0] din,
  output logic [31:0] dout
);
  // pick the lane arrangement
  always_comb begin
    case (dma_crc_pkg::byte_order_t'(order_sel))
      dma_crc_pkg::ORDER_KEEP: dout = din;
      dma_crc_pkg::ORDER_WORD_REV: dout = {din[7:0], din[15:8], din[23:16], din[31:24]};
      dma_crc_pkg::ORDER_HALF_SWAP: dout = {din[15:0], din[31:16]};
      dma_crc_pkg::ORDER_HALF_REV: dout = {din[23:16], din[31:24], din[7:0], din[15:8]};
      default: dout = din;
    endcase
  end
endmodule

// [crc_engine.sv]
// one-word step of the lfsr crc or the ip header checksum
`timescale 1ns/10ps
module crc_engine #(
  parameter int DATA_W = 32
) (
  input wire logic ip_mode,
  input wire logic reflect,
  input wire logic [4:0] poly_length,
  input wire logic [DATA_W-1:0] poly,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [DATA_W-1:0] acc_in,
  output logic [DATA_W-1:0] acc_out
);
  logic [15:0] h0_rev; // low half-word, bits reversed
  logic [15:0] h1_rev; // high half-word, bits reversed
  // bit reversal of each half-word for reflected checksum
  genvar g;
  for (g = 0; g < 16; g++) begin : g_rev
    assign h0_rev[g] = data_in[15-g];
    assign h1_rev[g] = data_in[31-g];
  end
  // serial lfsr over all data bits, or ones complement half-word sum
  always_comb begin
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] mask;
    logic fb;
    logic d;
    logic [16:0] s;
    logic [15:0] h0;
    logic [15:0] h1;
    a = acc_in;
    mask = '0;
    fb = 1'b0;
    d = 1'b0;
    s = '0;
    h0 = '0;
    h1 = '0;
    // register length is the field plus one
    for (int i = 0; i < DATA_W; i++) begin
      mask[i] = (5'(i) <= poly_length);
    end
    a = a & mask;
    for (int i = 0; i < DATA_W; i++) begin
      // reflected feeds lsb first, else msb first
      d = reflect ? data_in[i] : data_in[DATA_W-1-i];
      fb = a[poly_length] ^ d;
      a = (a << 1) & mask;
      if (fb) begin
        a = a ^ (poly & mask);
      end
    end
    // ip sum takes no notice of poly_length
    h0 = reflect ? h0_rev : data_in[15:0];
    h1 = reflect ? h1_rev : data_in[31:16];
    s = {1'b0, acc_in[15:0]} + {1'b0, h0};
    s = {1'b0, s[15:0]} + {16'h0000, s[16]};
    s = {1'b0, s[15:0]} + {1'b0, h1};
    s = {1'b0, s[15:0]} + {16'h0000, s[16]};
    acc_out = ip_mode ? {16'h0000, s[15:0]} : a;
  end
endmodule

// [dma_src_model.sv]
// channel engine model feeding source words and block completions
`timescale 1ns/10ps
module dma_src_model (
  input wire logic ref_clk,
  output logic src_valid,
  output logic [2:0] src_chan,
  output logic [31:0] src_data,
  output logic block_done,
  output logic [2:0] block_done_chan,
  output logic [255:0] dest_start_address
);
  logic [31:0] q[$]; // words of the next block
  // fixed start address per channel
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      dest_start_address[n*32 +: 32] = 32'h2000_0000 + 32'(n) * 32'h0000_0100;
    end
  end
  // idle bus at time zero
  initial begin
    src_valid = 1'b0;
    src_chan = 3'h0;
    src_data = 32'h0000_0000;
    block_done = 1'b0;
    block_done_chan = 3'h0;
  end
  // idle data lines toggle so no stale word looks valid
  task automatic send(input logic [2:0] ch, input int gap);
    while (q.size() > 0) begin
      @(posedge ref_clk);
      src_valid <= 1'b1;
      src_chan <= ch;
      src_data <= q.pop_front();
      for (int i = 0; i < gap; i++) begin
        @(posedge ref_clk);
        src_valid <= 1'b0;
        src_data <= ~src_data;
      end
    end
    @(posedge ref_clk);
    src_valid <= 1'b0;
    src_data <= ~src_data;
    block_done <= 1'b1;
    block_done_chan <= ch;
    @(posedge ref_clk);
    block_done <= 1'b0;
    block_done_chan <= ~ch;
  endtask
endmodule

// [dma_crc_unit_test.sv]
// self-checking bench of the dma checksum unit
`timescale 1ns/10ps
module dma_crc_unit_test;
  logic ref_clk, reset, reg_wr, reg_rd, src_valid, block_done, dst_valid, crc_wr_valid;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, src_data, dst_data, crc_wr_addr, crc_wr_data;
  logic [2:0] src_chan, block_done_chan, dst_chan;
  logic [255:0] dest_start_address;
  logic [31:0] dq[$]; // destination words seen
  logic [2:0] cq[$]; // channels of those words
  int n_crc, cyc, fail_count, n_compared;

  dma_crc_unit DUT (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_valid(src_valid),
    .src_chan(src_chan), .src_data(src_data), .block_done(block_done),
    .block_done_chan(block_done_chan), .dest_start_address(dest_start_address),
    .dst_valid(dst_valid), .dst_chan(dst_chan), .dst_data(dst_data),
    .crc_wr_valid(crc_wr_valid), .crc_wr_addr(crc_wr_addr), .crc_wr_data(crc_wr_data)
  );
  dma_src_model src (
    .ref_clk(ref_clk), .src_valid(src_valid), .src_chan(src_chan), .src_data(src_data),
    .block_done(block_done), .block_done_chan(block_done_chan),
    .dest_start_address(dest_start_address)
  );

  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // collect outputs and cut a hang short
  always @(posedge ref_clk) begin
    cyc++;
    if (dst_valid === 1'b1) begin
      dq.push_back(dst_data);
      cq.push_back(dst_chan);
    end
    if (crc_wr_valid === 1'b1) n_crc++;
    if (cyc > 20000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read, data stands in the following cycle
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // restart the unit with control c, then send queued words on ch
  task automatic run(input logic [31:0] c, input logic [2:0] ch, input int g);
    wr(4'h0, c & ~32'h0000_0080);
    wr(4'h0, c);
    dq.delete();
    cq.delete();
    n_crc = 0;
    src.send(ch, g);
    repeat (3) @(posedge ref_clk);
  endtask

  function automatic logic [31:0] reord(input logic [31:0] w, input logic [1:0] o);
    case (o)
      2'h1: return {w[7:0], w[15:8], w[23:16], w[31:24]};
      2'h2: return {w[15:0], w[31:16]};
      2'h3: return {w[23:16], w[31:24], w[7:0], w[15:8]};
      default: return w;
    endcase
  endfunction
  // galois shift of one word, msb first unless reflected
  function automatic logic [31:0] lfsr(input logic [31:0] a, input logic [31:0] w,
      input logic [31:0] p, input int l, input logic r);
    logic [31:0] m;
    logic fb;
    m = (l == 32) ? 32'hFFFF_FFFF : ((32'h1 << l) - 32'h1);
    for (int b = 0; b < 32; b++) begin
      fb = a[l-1] ^ (r ? w[b] : w[31-b]);
      a = (a << 1) & m;
      if (fb) a = a ^ (p & m);
    end
    return a;
  endfunction
  // ones-complement sum, low half-word first
  function automatic logic [31:0] ipsum(input logic [31:0] s, input logic [31:0] w,
      input logic r);
    logic [15:0] h;
    for (int i = 0; i < 2; i++) begin
      h = i ? w[31:16] : w[15:0];
      if (r) h = {<<{h}};
      s = s + 32'(h);
      s = (s & 32'h0000_FFFF) + (s >> 16);
    end
    return s;
  endfunction

  // reset values, masking, unmapped place, append blocked by write order
  task automatic t_regs();
    rdchk(4'h0, 32'h0000_0000);
    rdchk(4'h8, 32'h0000_0000);
    wr(4'h0, 32'hFFFF_FFFF);
    rdchk(4'h0, 32'h3900_1FA7);
    wr(4'h0, 32'hC6FF_E040);
    rdchk(4'h0, 32'h0000_0040);
    rdchk(4'hC, 32'h0000_0000);
    // the result register ignores writes
    wr(4'h4, 32'hFFFF_FFFF);
    rdchk(4'h4, 32'h0000_0000);
    src.q.push_back(32'h0BAD_F00D);
    run(32'h0800_00C0, 3'h0, 0);
    chk(32'(n_crc), 32'h0);
    chk(32'(dq.size()), 32'h1);
  endtask
  // every byte order with and without write order
  task automatic t_order();
    logic [31:0] w;
    for (int k = 0; k < 8; k++) begin
      w = 32'h1122_3344 + 32'(k);
      src.q.push_back(w);
      run(32'h0000_0085 | (32'(k) << 27), 3'h5, 0);
      chk(32'(dq.size()), 32'h1);
      chk(32'(cq[0]), 32'h5);
      chk(dq[0], k[0] ? reord(w, k[2:1]) : w);
    end
  endtask
  // every channel attached, its neighbour not, then disabled
  task automatic t_chan();
    for (int k = 0; k < 8; k++) begin
      src.q.push_back(32'hA1B2_C3D4);
      run(32'h1800_0080 | 32'(k), 3'(k), 0);
      chk(dq[0], 32'hD4C3_B2A1);
      chk(32'(cq[0]), 32'(k));
      src.q.push_back(32'hA1B2_C3D4);
      run(32'h1800_0080 | 32'(k), 3'(k + 1), 0);
      chk(dq[0], 32'hA1B2_C3D4);
    end
    src.q.push_back(32'hA1B2_C3D4);
    run(32'h1800_0000, 3'h0, 0);
    chk(dq[0], 32'hA1B2_C3D4);
  endtask
  // append with lfsr of several lengths, reflection and orders
  task automatic t_lfsr();
    logic [31:0] c, e, w;
    int l;
    for (int k = 0; k < 3; k++) begin
      l = (k == 0) ? 32 : ((k == 1) ? 16 : 5);
      c = 32'h0000_00C0 | (32'(k) << 28) | (32'(k & 1) << 24) | (32'(l - 1) << 8) | 32'(k + 2);
      e = 32'h0000_0000;
      wr(4'h8, 32'h04C1_1DB7);
      for (int i = 0; i < 3; i++) begin
        w = 32'hA5C3_0F96 + 32'(i + k) * 32'h0103_0507;
        src.q.push_back(w);
        e = lfsr(e, reord(w, 2'(k)), 32'h04C1_1DB7, l, k[0]);
      end
      run(c, 3'(k + 2), k);
      chk(32'(n_crc), 32'h1);
      chk(32'(dq.size()), 32'h0);
      chk(crc_wr_addr, 32'h2000_0000 + 32'(k + 2) * 32'h0000_0100);
      chk(crc_wr_data, e);
      rdchk(4'h4, e);
      src.q.push_back(w);
      run(c, 3'(k + 3), 0);
      chk(32'(n_crc), 32'h0);
      chk(32'(dq.size()), 32'h1);
    end
  endtask
  // ip checksum, both bit orders, length field set but ignored
  task automatic t_ip();
    logic [31:0] s, w;
    for (int k = 0; k < 2; k++) begin
      s = 32'h0000_0000;
      for (int i = 0; i < 2; i++) begin
        w = 32'h4500_0073 + 32'(i + k) * 32'h0001_C0A8;
        src.q.push_back(w);
        s = ipsum(s, w, k[0]);
      end
      run(32'h0000_09E1 | (32'(k) << 24), 3'h1, 1);
      chk(32'(n_crc), 32'h1);
      chk(crc_wr_data, {16'h0000, ~s[15:0]});
      rdchk(4'h4, {16'h0000, ~s[15:0]});
    end
  endtask

  // reset in mid-run returns every field to zero
  task automatic t_reset();
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rdchk(4'h0, 32'h0000_0000);
    rdchk(4'h4, 32'h0000_0000);
    rdchk(4'h8, 32'h0000_0000);
  endtask

  // main sequence
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs();
    t_order();
    t_chan();
    t_lfsr();
    t_ip();
    t_reset();
    final_report();
  end
endmodule
